// File: otg_ctrl_rise_regs.sv
// otg control register with set/clear aliases and rising-event enables
//
// Operation
// - set alias sets bits written one
// - clear alias clears bits written one
// - aliases have no storage, read base
// - control bit order fixed, seven to zero
// - enabled rising comparator edges raise notifications
// - all five rise enables reset to one
// - bit four gates id-ground rise
// - id rise masked while pullup off, 50ms after
// - bit three gates session-end rise
// - bit two gates session-valid rise
// - bit one gates bus-valid rise
// - bit zero gates disconnect, host mode only
// - base control register at 0x0a read/write
// - supply enable out needs drive and select
`timescale 1ns/1ps
module otg_ctrl_rise_regs #(
    parameter int id_settle_cycles = otg_regs_pkg::id_settle_cycles
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic       id_ground_indication,
    input  wire logic       session_end_comparator,
    input  wire logic       session_valid_comparator,
    input  wire logic       bus_valid_comparator,
    input  wire logic       host_disconnect_detect,
    output logic      [4:0] rise_event,
    output logic            ext_supply_indicator_select,
    output logic            external_supply_select,
    output logic            supply_drive_request,
    output logic            bus_charge_enable,
    output logic            bus_discharge_enable,
    output logic            minus_line_pulldown_en,
    output logic            plus_line_pulldown_en,
    output logic            id_line_pullup_en,
    output logic            external_supply_enable_out
);
    typedef enum logic [1:0] {id_off = 2'b00, id_settle = 2'b01, id_live = 2'b11} id_state_t;

    logic [7:0]  otg_control_reg;
    logic [7:0]  rising_enable_reg;
    logic [31:0] settle_count_reg;
    id_state_t   id_state_reg;
    logic [4:0]  rise_level;
    logic [4:0]  rise_gate;
    logic        host_mode;
    logic        id_rise_ok;

    // one storage word; the alias addresses only modify it
    always_ff @(posedge clock)
    begin
        if (rst)
            otg_control_reg <= otg_regs_pkg::otg_control_reset;
        else if (reg_write)
        begin
            if (reg_addr == otg_regs_pkg::addr_otg_control)
                otg_control_reg <= reg_wdata;
            else if (reg_addr == otg_regs_pkg::addr_otg_control_set)
                otg_control_reg <= otg_control_reg | reg_wdata;
            else if (reg_addr == otg_regs_pkg::addr_otg_control_clear)
                otg_control_reg <= otg_control_reg & ~reg_wdata;
        end
    end

    // reserved enable bits never store anything
    always_ff @(posedge clock)
    begin
        if (rst)
            rising_enable_reg <= otg_regs_pkg::rising_enable_reset;
        else if (reg_write && reg_addr == otg_regs_pkg::addr_rising_enable)
            rising_enable_reg <= reg_wdata & otg_regs_pkg::rising_enable_mask;
    end

    // read mux; unmapped addresses read zero and drop reg_hit
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end
        else if (reg_read)
        begin
            if (reg_addr == otg_regs_pkg::addr_otg_control
                || reg_addr == otg_regs_pkg::addr_otg_control_set
                || reg_addr == otg_regs_pkg::addr_otg_control_clear)
            begin
                reg_rdata <= otg_control_reg;
                reg_hit   <= 1'b1;
            end
            else if (reg_addr == otg_regs_pkg::addr_rising_enable)
            begin
                reg_rdata <= rising_enable_reg;
                reg_hit   <= 1'b1;
            end
            else
            begin
                reg_rdata <= 8'h00;
                reg_hit   <= 1'b0;
            end
        end
        else
            reg_hit <= 1'b0;
    end

    // id settling: the id line needs time after the pullup switches on
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            id_state_reg     <= id_off;
            settle_count_reg <= 32'h0;
        end
        else if (!otg_control_reg[otg_regs_pkg::bit_id_pullup])
        begin
            id_state_reg     <= id_off;
            settle_count_reg <= 32'h0;
        end
        else
        begin
            case (id_state_reg)
                id_off:
                begin
                    id_state_reg     <= id_settle;
                    settle_count_reg <= 32'h0;
                end
                id_settle:
                begin
                    if (settle_count_reg >= 32'(id_settle_cycles - 1))
                        id_state_reg <= id_live;
                    else
                        settle_count_reg <= settle_count_reg + 32'h1;
                end
                id_live:
                    id_state_reg <= id_live;
                default:
                    id_state_reg <= id_off;
            endcase
        end
    end

    // the live bit lags the pullup by one edge, so the pullup itself masks at once
    assign id_rise_ok = (id_state_reg == id_live)
                      & otg_control_reg[otg_regs_pkg::bit_id_pullup];
    assign host_mode  = otg_control_reg[otg_regs_pkg::bit_plus_pulldown]
                      & otg_control_reg[otg_regs_pkg::bit_minus_pulldown];

    // comparator levels in enable-bit order
    assign rise_level[otg_regs_pkg::bit_id_ground_rise]       = id_ground_indication;
    assign rise_level[otg_regs_pkg::bit_session_end_rise]     = session_end_comparator;
    assign rise_level[otg_regs_pkg::bit_session_valid_rise]   = session_valid_comparator;
    assign rise_level[otg_regs_pkg::bit_bus_valid_rise]       = bus_valid_comparator;
    assign rise_level[otg_regs_pkg::bit_host_disconnect_rise] = host_disconnect_detect;

    // enables, plus the automatic id and host-mode gating
    assign rise_gate[4] = rising_enable_reg[otg_regs_pkg::bit_id_ground_rise] & id_rise_ok;
    assign rise_gate[3] = rising_enable_reg[otg_regs_pkg::bit_session_end_rise];
    assign rise_gate[2] = rising_enable_reg[otg_regs_pkg::bit_session_valid_rise];
    assign rise_gate[1] = rising_enable_reg[otg_regs_pkg::bit_bus_valid_rise];
    assign rise_gate[0] = rising_enable_reg[otg_regs_pkg::bit_host_disconnect_rise] & host_mode;

    rise_detect #(
        .width (5)
    ) rise_detect_inst (
        .clock       (clock),
        .rst         (rst),
        .level_in    (rise_level),
        .enable      (rise_gate),
        .event_pulse (rise_event)
    );

    // control outputs straight from the register, fixed bit order
    assign ext_supply_indicator_select = otg_control_reg[otg_regs_pkg::bit_ext_indicator_select];
    assign external_supply_select = otg_control_reg[otg_regs_pkg::bit_external_supply_select];
    assign supply_drive_request   = otg_control_reg[otg_regs_pkg::bit_supply_drive];
    assign bus_charge_enable      = otg_control_reg[otg_regs_pkg::bit_bus_charge];
    assign bus_discharge_enable   = otg_control_reg[otg_regs_pkg::bit_bus_discharge];
    assign minus_line_pulldown_en = otg_control_reg[otg_regs_pkg::bit_minus_pulldown];
    assign plus_line_pulldown_en  = otg_control_reg[otg_regs_pkg::bit_plus_pulldown];
    assign id_line_pullup_en      = otg_control_reg[otg_regs_pkg::bit_id_pullup];

    // no internal supply exists, so both bits are needed
    assign external_supply_enable_out = supply_drive_request & external_supply_select;

    a_set_alias: assert property (@(posedge clock) disable iff (rst)
        reg_write && reg_addr == otg_regs_pkg::addr_otg_control_set
        |=> otg_control_reg == ($past(otg_control_reg) | $past(reg_wdata)))
        else $error("set alias wrong");
    a_clear_alias: assert property (@(posedge clock) disable iff (rst)
        reg_write && reg_addr == otg_regs_pkg::addr_otg_control_clear
        |=> otg_control_reg == ($past(otg_control_reg) & ~$past(reg_wdata)))
        else $error("clear alias wrong");
    a_alias_read: assert property (@(posedge clock) disable iff (rst)
        reg_read && !reg_write && (reg_addr == otg_regs_pkg::addr_otg_control_set
        || reg_addr == otg_regs_pkg::addr_otg_control_clear)
        |=> reg_rdata == otg_control_reg && reg_hit)
        else $error("alias read mismatch");
    a_enable_reserved: assert property (@(posedge clock) disable iff (rst)
        reg_read && reg_addr == otg_regs_pkg::addr_rising_enable
        |=> reg_rdata[7:5] == 3'h0 && rising_enable_reg[7:5] == 3'h0)
        else $error("reserved enable bits set");
    a_reset_enables: assert property (@(posedge clock)
        $past(rst) |-> rising_enable_reg == otg_regs_pkg::rising_enable_reset)
        else $error("enables not reset");
    a_id_masked: assert property (@(posedge clock) disable iff (rst)
        !id_line_pullup_en |=> !rise_event[4])
        else $error("id rise while pullup off");
    a_host_only: assert property (@(posedge clock) disable iff (rst)
        !host_mode |=> !rise_event[0])
        else $error("disconnect outside host mode");
    a_rise_event: assert property (@(posedge clock) disable iff (rst)
        session_end_comparator && !$past(session_end_comparator)
        && rising_enable_reg[3] |=> rise_event[3])
        else $error("missed session end rise");
    a_rise_gated: assert property (@(posedge clock) disable iff (rst)
        !rising_enable_reg[1] |=> !rise_event[1])
        else $error("bus valid rise not gated");
    a_supply_out: assert property (@(posedge clock) disable iff (rst)
        external_supply_enable_out == (otg_control_reg[5] && otg_control_reg[6]))
        else $error("supply enable wrong");
    c_set_write: cover property (@(posedge clock)
        reg_write && reg_addr == otg_regs_pkg::addr_otg_control_set);
    c_id_live: cover property (@(posedge clock) id_state_reg == id_live);
    c_valid_event: cover property (@(posedge clock) rise_event[2]);
endmodule // otg_ctrl_rise_regs

// File: otg_regs_pkg.sv
// constants for the otg control and rising-event enable register slice
package otg_regs_pkg;
    localparam logic [5:0] addr_otg_control        = 6'h0a;
    localparam logic [5:0] addr_otg_control_set    = 6'h0b;
    localparam logic [5:0] addr_otg_control_clear  = 6'h0c;
    localparam logic [5:0] addr_rising_enable      = 6'h0d;
    localparam logic [7:0] otg_control_reset       = 8'h06;
    localparam logic [7:0] rising_enable_reset     = 8'h1f;
    localparam logic [7:0] rising_enable_mask      = 8'h1f;
    localparam int bit_ext_indicator_select = 7;
    localparam int bit_external_supply_select = 6;
    localparam int bit_supply_drive = 5;
    localparam int bit_bus_charge = 4;
    localparam int bit_bus_discharge = 3;
    localparam int bit_minus_pulldown = 2;
    localparam int bit_plus_pulldown = 1;
    localparam int bit_id_pullup = 0;
    localparam int bit_id_ground_rise = 4;
    localparam int bit_session_end_rise = 3;
    localparam int bit_session_valid_rise = 2;
    localparam int bit_bus_valid_rise = 1;
    localparam int bit_host_disconnect_rise = 0;
    localparam int clock_rate_hz = 40000000;
    localparam int id_settle_time_ms = 50;
    localparam int id_settle_cycles = clock_rate_hz / 1000 * id_settle_time_ms;
endpackage

// File: rise_detect.sv
// rising-edge detector with per-bit enable for the comparator events
`timescale 1ns/1ps
module rise_detect #(
    parameter int width = 5
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [width-1:0] level_in,
    input  wire logic [width-1:0] enable,
    output logic      [width-1:0] event_pulse
);
    logic [width-1:0] last_reg;

    // previous level per source; follows the pin through reset as well, so a
    // comparator that already sits high at release is not taken for a rise
    always_ff @(posedge clock)
    begin
        last_reg <= level_in;
    end

    // one gate per source
    genvar i;
    generate
        for (i = 0; i < width; i++)
        begin : g_bit
            always_ff @(posedge clock)
            begin
                if (rst)
                    event_pulse[i] <= 1'b0;
                else
                    event_pulse[i] <= level_in[i] & ~last_reg[i] & enable[i];
            end
        end
    endgenerate
endmodule // rise_detect

// File: link_model.sv
// link-side model issuing register writes and reads to the phy
`timescale 1ns/1ps
module link_model (
    input  wire logic       clock,
    output logic            reg_write,
    output logic            reg_read,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_hit
);
    // idle bus from time zero
    initial
    begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 6'h3f;
        reg_wdata = 8'h00;
    end
    // one write held through its taking edge, then released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr  = ~a; // released lines must not look stale
        reg_wdata = ~d;
    endtask
    // one read; answer taken at the falling edge half a cycle after the taking edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic h);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clock);
        d        = reg_rdata;
        h        = reg_hit;
        reg_read = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // link_model

// File: otg_ctrl_alias_and_rise_irq_enable_tb_top.sv
// self-checking bench for the otg control aliases and rising-event enables
`timescale 1ns/1ps
module otg_ctrl_alias_and_rise_irq_enable_tb_top;
    localparam int settle = 8;
    logic        clock;
    logic        rst;
    logic        reg_write;
    logic        reg_read;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_hit;
    logic [4:0]  cmp;
    logic [4:0]  rise_event;
    wire  [7:0]  ctl_out;
    logic        supply_en;
    logic [7:0]  ctl_m;
    logic [7:0]  en_m;
    logic [7:0]  rdv;
    logic [7:0]  d;
    logic [5:0]  a;
    logic [3:0]  r;
    logic        hit;
    logic [13:0] corner [4] = '{14'h0b60, 14'h0b00, 14'h0c20, 14'h0cff};
    int          mismatches;
    int          checks_done;

    link_model link_model_inst (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
    otg_ctrl_rise_regs #(.id_settle_cycles(settle)) otg_ctrl_rise_regs_inst (
        .clock(clock), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .id_ground_indication(cmp[4]), .session_end_comparator(cmp[3]),
        .session_valid_comparator(cmp[2]), .bus_valid_comparator(cmp[1]),
        .host_disconnect_detect(cmp[0]), .rise_event(rise_event),
        .ext_supply_indicator_select(ctl_out[7]), .external_supply_select(ctl_out[6]),
        .supply_drive_request(ctl_out[5]), .bus_charge_enable(ctl_out[4]),
        .bus_discharge_enable(ctl_out[3]), .minus_line_pulldown_en(ctl_out[2]),
        .plus_line_pulldown_en(ctl_out[1]), .id_line_pullup_en(ctl_out[0]),
        .external_supply_enable_out(supply_en));

    // 40 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // disconnect only counts with both pulldowns on
    function automatic logic [4:0] exp_rise(input logic [4:0] rr, input logic [7:0] en,
                                            input logic [7:0] ctl);
        exp_rise = rr & en[4:0];
        if (!(ctl[1] && ctl[2]))
            exp_rise[0] = 1'b0;
    endfunction

    task automatic rd_chk(input logic [5:0] ad, input logic [7:0] exp, input string what);
        link_model_inst.rd(ad, rdv, hit);
        check(what, rdv, exp);
        check("hit", {7'h0, hit}, 8'h01);
    endtask

    task automatic out_chk();
        check("ctl_out", ctl_out, ctl_m);
        check("supply_en", {7'h0, supply_en}, {7'h0, ctl_m[6] & ctl_m[5]});
    endtask

    // raise comparators for one cycle; the event pulse must be exactly one cycle
    task automatic pulse(input logic [4:0] rr, input logic [4:0] exp);
        cmp = rr;
        @(negedge clock);
        check("rise_event", {3'h0, rise_event}, {3'h0, exp});
        cmp = 5'h00;
        @(negedge clock);
        check("rise_idle", {3'h0, rise_event}, 8'h00);
    endtask

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clock);
        mismatches++;
        conclude();
    end

    // main sequence
    initial
    begin
        mismatches  = 0;
        checks_done = 0;
        rst         = 1'b1;
        cmp         = 5'h00;
        void'($urandom(32'hc5be));
        repeat (3) @(negedge clock);
        rst   = 1'b0;
        ctl_m = 8'h06;
        en_m  = 8'h1f;
        out_chk();
        rd_chk(6'h0a, 8'h06, "ctl reset");
        rd_chk(6'h0d, 8'h1f, "en reset");
        // corners first, then random traffic over all four addresses
        for (int i = 0; i < 28; i++)
        begin
            {a, d} = (i < 4) ? corner[i] : {6'h0a + 6'($urandom % 4), 8'($urandom)};
            link_model_inst.wr(a, d);
            case (a)
                6'h0a: ctl_m = d;
                6'h0b: ctl_m = ctl_m | d;
                6'h0c: ctl_m = ctl_m & ~d;
                default: en_m = d & 8'h1f;
            endcase
            out_chk();
            rd_chk(6'h0a + 6'($urandom % 3), ctl_m, "ctl");
            rd_chk(6'h0d, en_m, "en");
        end
        link_model_inst.rd(6'h20, rdv, hit);
        check("unmapped", rdv, 8'h00);
        check("unmapped hit", {7'h0, hit}, 8'h00);
        // comparator rises against random enables, in and out of host mode
        for (int i = 0; i < 16; i++)
        begin
            ctl_m = (i % 3 == 2) ? 8'h02 : 8'h06;
            en_m  = (i == 0) ? 8'h1f : 8'($urandom) & 8'h1f;
            r     = (i == 0) ? 4'hf : 4'($urandom);
            link_model_inst.wr(6'h0a, ctl_m);
            link_model_inst.wr(6'h0d, en_m);
            pulse({1'b0, r}, exp_rise({1'b0, r}, en_m, ctl_m));
        end
        // id rise: masked with pullup off and during the settle window
        link_model_inst.wr(6'h0d, 8'h1f);
        pulse(5'h10, 5'h00);
        link_model_inst.wr(6'h0b, 8'h01);
        pulse(5'h10, 5'h00);
        repeat (settle - 3) @(negedge clock);
        pulse(5'h10, 5'h00);
        pulse(5'h10, 5'h10);
        link_model_inst.wr(6'h0d, 8'h0f);
        pulse(5'h10, 5'h00);
        // discharge until session end rises, then the link stops it
        link_model_inst.wr(6'h0b, 8'h08);
        pulse(5'h08, 5'h08);
        link_model_inst.wr(6'h0c, 8'h08);
        check("discharge", {7'h0, ctl_out[3]}, 8'h00);
        // mid-run reset brings both registers back to their reset values
        rst = 1'b1;
        @(negedge clock);
        rst   = 1'b0;
        ctl_m = 8'h06;
        out_chk();
        rd_chk(6'h0c, 8'h06, "ctl re-reset");
        rd_chk(6'h0d, 8'h1f, "en re-reset");
        conclude();
    end
endmodule // otg_ctrl_alias_and_rise_irq_enable_tb_top
